// ### rtl/aifst_pkg.sv
// Package for the analog input fault and status tree.
// Assumes a single 25 MHz clock domain and a synchronous active-high reset.
package aifst_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CHAN = 16;
    localparam int WORD_W   = 16;
    localparam int STAT_W   = 8;

    // ==========================================================
    // Module fault word fields
    localparam int MF_GROUP_BIT = 15;
    localparam int MF_CALIP_BIT = 10;
    localparam int MF_CALER_BIT = 9;

    // ==========================================================
    // Channel status word fields
    localparam int CS_CAL_BIT   = 7;
    localparam int CS_BELOW_BIT = 6;
    localparam int CS_ABOVE_BIT = 5;
    localparam int CS_SLOPE_BIT = 4;
    localparam int CS_LOW_BIT   = 3;
    localparam int CS_HIGH_BIT  = 2;
    localparam int CS_LL_BIT    = 1;
    localparam int CS_HH_BIT    = 0;

    // ==========================================================
    // Wiring formats and their active channel masks
    localparam logic [1:0] FMT_SINGLE = 2'h0;
    localparam logic [1:0] FMT_DIFF   = 2'h1;
    localparam logic [1:0] FMT_HSDIFF = 2'h2;

    localparam logic [15:0] MASK_SINGLE = 16'hFFFF;
    localparam logic [15:0] MASK_DIFF   = 16'h00FF;
    localparam logic [15:0] MASK_HSDIFF = 16'h000F;
    localparam logic [15:0] WORD_ZERO   = 16'h0000;
    localparam logic [15:0] WORD_ONES   = 16'hFFFF;
    localparam logic [7:0]  STAT_ZERO   = 8'h00;

    // Per-channel raw condition flags from the conversion and alarm logic.
    typedef struct packed {
        logic cal_err;
        logic below;
        logic above;
        logic slope;
        logic low;
        logic high;
        logic low_low;
        logic high_high;
    } aifst_chan_flags_t;

    // Frame of status words multicast along with channel data.
    typedef struct packed {
        logic [15:0]      module_fault;
        logic [15:0]      chan_fault;
        logic [16*8-1:0]  chan_status;
    } aifst_frame_t;

endpackage : aifst_pkg

// ### rtl/aifst_tree.sv
// Fault and status roll-up for a sixteen-channel analog input module.
// Assumes flag inputs are synchronous to mclk; data_strobe marks each channel data transfer.
`timescale 1ns/10ps

module aifst_tree #(
    parameter int NCH = aifst_pkg::NUM_CHAN
) (
    // Clock and reset.
    input  wire logic                         mclk,
    input  wire logic                         srst,
    // Configuration and conditions.
    input  wire logic [1:0]                   wiring_fmt,
    input  wire logic [NCH-1:0]               chan_calibrating,
    input  wire logic                         comm_fault,
    input  wire logic [NCH-1:0]               at_or_below_min,
    input  wire logic [NCH-1:0]               at_or_above_max,
    input  wire aifst_pkg::aifst_chan_flags_t [NCH-1:0] alarm_flags,
    input  wire logic                         data_strobe,
    // Multicast status frame.
    output aifst_pkg::aifst_frame_t           frame_ff,
    output logic                              frame_valid_ff
);

    // ==========================================================
    // Decode helpers
    // Active channel mask for a wiring format; unknown codes expose nothing.
    function automatic logic [15:0] fmt_mask(input logic [1:0] fmt);
        case (fmt)
            aifst_pkg::FMT_SINGLE: fmt_mask = aifst_pkg::MASK_SINGLE;
            aifst_pkg::FMT_DIFF:   fmt_mask = aifst_pkg::MASK_DIFF;
            aifst_pkg::FMT_HSDIFF: fmt_mask = aifst_pkg::MASK_HSDIFF;
            default:               fmt_mask = aifst_pkg::WORD_ZERO;
        endcase
    endfunction : fmt_mask

    logic [15:0]            act_mask;
    logic [15:0]            raw_range;
    logic [16*8-1:0]        stat_words;
    logic [15:0]            cal_errs;

    // ==========================================================
    // Per-channel status words
    // Alarm inputs are taken from the alarm logic; only range and cal flags are decoded here.
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_chan
            if (g < NCH)
            begin : g_live
                logic [7:0] w;
                always_comb
                begin
                    w = aifst_pkg::STAT_ZERO;
                    w[aifst_pkg::CS_CAL_BIT]   = alarm_flags[g].cal_err;
                    w[aifst_pkg::CS_BELOW_BIT] = at_or_below_min[g];
                    w[aifst_pkg::CS_ABOVE_BIT] = at_or_above_max[g];
                    w[aifst_pkg::CS_SLOPE_BIT] = alarm_flags[g].slope;
                    w[aifst_pkg::CS_LOW_BIT]   = alarm_flags[g].low;
                    w[aifst_pkg::CS_HIGH_BIT]  = alarm_flags[g].high;
                    w[aifst_pkg::CS_LL_BIT]    = alarm_flags[g].low_low;
                    w[aifst_pkg::CS_HH_BIT]    = alarm_flags[g].high_high;
                end
                // Inactive channels present a zero word.
                assign stat_words[g*8 +: 8] = act_mask[g] ? w : aifst_pkg::STAT_ZERO;
                assign raw_range[g] = at_or_below_min[g] | at_or_above_max[g];
                assign cal_errs[g]  = act_mask[g] & alarm_flags[g].cal_err;
            end
            else
            begin : g_dead
                assign stat_words[g*8 +: 8] = aifst_pkg::STAT_ZERO;
                assign raw_range[g] = 1'b0;
                assign cal_errs[g]  = 1'b0;
            end
        end
    endgenerate

    assign act_mask = fmt_mask(wiring_fmt);

    // ==========================================================
    // Roll-up of channel fault and module fault words
    // Comms fault outranks calibration since it masks every channel regardless of format.
    logic                    calib_any;
    aifst_pkg::aifst_frame_t nxt_frame;
    logic                    nxt_frame_valid;

    assign calib_any = |chan_calibrating;

    always_comb
    begin
        nxt_frame = frame_ff;
        nxt_frame_valid = 1'b0;
        if (data_strobe)
        begin
            nxt_frame_valid = 1'b1;
            if (comm_fault)
                nxt_frame.chan_fault = aifst_pkg::WORD_ONES;
            else if (calib_any)
                nxt_frame.chan_fault = act_mask;
            else
                nxt_frame.chan_fault = raw_range & act_mask;
            nxt_frame.module_fault = aifst_pkg::WORD_ZERO;
            nxt_frame.module_fault[aifst_pkg::MF_GROUP_BIT] = |nxt_frame.chan_fault;
            nxt_frame.module_fault[aifst_pkg::MF_CALIP_BIT] = calib_any;
            nxt_frame.module_fault[aifst_pkg::MF_CALER_BIT] = |cal_errs;
            nxt_frame.chan_status = stat_words;
        end
    end

    // Registers only; every output comes straight from here.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            frame_ff       <= '0;
            frame_valid_ff <= 1'b0;
        end
        else
        begin
            frame_ff       <= nxt_frame;
            frame_valid_ff <= nxt_frame_valid;
        end
    end

    // ==========================================================
    // Assertions
    sequence s_strobe_comm;
        data_strobe && comm_fault;
    endsequence

    // A strobe with neither override active, so the range flags alone decide the channel word.
    sequence s_strobe_quiet;
        data_strobe && !comm_fault && !calib_any;
    endsequence

    // A strobe taken while some channel calibrates and the link to the owner is healthy.
    sequence s_strobe_calib;
        data_strobe && !comm_fault && calib_any;
    endsequence

    a_send_on_strobe: assert property (@(posedge mclk) disable iff (srst)
        data_strobe |=> frame_valid_ff) else $error("frame not sent after strobe");
    a_no_spurious_send: assert property (@(posedge mclk) disable iff (srst)
        !data_strobe |=> !frame_valid_ff) else $error("frame sent without strobe");
    a_comm_forces_all: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_comm |=> frame_ff.chan_fault == 16'hFFFF) else $error("comm fault not all ones");
    a_cal_pattern: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && !comm_fault && calib_any && wiring_fmt == aifst_pkg::FMT_DIFF
        |=> frame_ff.chan_fault == 16'h00FF) else $error("cal pattern wrong");
    a_group_summary: assert property (@(posedge mclk) disable iff (srst)
        frame_valid_ff |-> frame_ff.module_fault[15] == (frame_ff.chan_fault != 16'h0000))
        else $error("group summary mismatch");
    a_unused_zero: assert property (@(posedge mclk) disable iff (srst)
        frame_valid_ff |-> frame_ff.module_fault[14:11] == 4'h0 && frame_ff.module_fault[8:0] == 9'h000)
        else $error("unused module bits set");
    a_calip_flag: assert property (@(posedge mclk) disable iff (srst)
        data_strobe |=> frame_ff.module_fault[10] == $past(calib_any)) else $error("calibrating flag wrong");
    a_range_sets_bit: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && act_mask[0] && at_or_above_max[0] |=> frame_ff.chan_fault[0] && frame_ff.chan_status[5])
        else $error("overrange not reported");
    a_alarm_isolated: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && !comm_fault && !calib_any && at_or_below_min == '0 && at_or_above_max == '0
        |=> frame_ff.chan_fault == 16'h0000) else $error("alarm leaked upward");
    a_hsdiff_status: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && wiring_fmt == aifst_pkg::FMT_HSDIFF |=> frame_ff.chan_status[16*8-1:4*8] == '0)
        else $error("inactive status word nonzero");

    // Single-ended calibration must force every one of the sixteen channel bits.
    a_single_cal: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_calib ##0 (wiring_fmt == aifst_pkg::FMT_SINGLE) |=> frame_ff.chan_fault == aifst_pkg::MASK_SINGLE)
        else $error("single-ended cal pattern wrong");

    // High-speed calibration forces only the four live channel bits.
    a_hsdiff_cal: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_calib ##0 (wiring_fmt == aifst_pkg::FMT_HSDIFF) |=> frame_ff.chan_fault == aifst_pkg::MASK_HSDIFF)
        else $error("high-speed cal pattern wrong");

    // A calibration error on a live channel must reach the module summary.
    a_calerr_summary: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && wiring_fmt == aifst_pkg::FMT_SINGLE && alarm_flags[0].cal_err
        |=> frame_ff.module_fault[aifst_pkg::MF_CALER_BIT]) else $error("cal error summary missing");

    // Channels beyond the differential count stay clear when nothing forces them.
    a_inactive_quiet: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_quiet ##0 (wiring_fmt == aifst_pkg::FMT_DIFF)
        |=> (frame_ff.chan_fault & ~aifst_pkg::MASK_DIFF) == aifst_pkg::WORD_ZERO) else $error("inactive bit set");

    // The controller relies on a nonzero module word to go looking further down.
    a_nonzero_module: assert property (@(posedge mclk) disable iff (srst)
        frame_valid_ff && frame_ff.chan_fault != aifst_pkg::WORD_ZERO |-> frame_ff.module_fault != aifst_pkg::WORD_ZERO)
        else $error("fault hidden from module word");

    // Between transfers the frame must not move, or a late reader would see a torn set of words.
    a_frame_holds: assert property (@(posedge mclk) disable iff (srst)
        !data_strobe |=> $stable(frame_ff)) else $error("frame changed without strobe");

    // Underrange on a live channel shows in both its status word and its fault bit.
    a_below_reported: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && act_mask[0] && at_or_below_min[0]
        |=> frame_ff.chan_fault[0] && frame_ff.chan_status[aifst_pkg::CS_BELOW_BIT]) else $error("underrange lost");

    // A rate alarm stays local to its own channel status word.
    a_slope_local: assert property (@(posedge mclk) disable iff (srst)
        data_strobe && act_mask[1] && alarm_flags[1].slope
        |=> frame_ff.chan_status[aifst_pkg::STAT_W + aifst_pkg::CS_SLOPE_BIT]) else $error("rate alarm misplaced");

    // The highest channel maps onto the highest fault bit.
    a_top_channel_bit: assert property (@(posedge mclk) disable iff (srst)
        s_strobe_quiet ##0 (wiring_fmt == aifst_pkg::FMT_SINGLE && at_or_above_max[NCH-1])
        |=> frame_ff.chan_fault[NCH-1]) else $error("top channel bit missing");

endmodule : aifst_tree

// ### verif/aifst_ctrl_model.sv
// Model of the owning controller that receives the multicast status frames.
// Assumes one mclk domain and the design's registered one-cycle frame pulse.
`timescale 1ns/10ps
// ==========================================================
// Controller model
module aifst_ctrl_model (
    // Clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   srst,
    // Multicast frame from the device.
    input  wire logic                   frame_valid_ff,
    input  wire aifst_pkg::aifst_frame_t frame_ff,
    // Reception record.
    output logic [31:0]                 rx_count_ff,
    output aifst_pkg::aifst_frame_t     rx_frame_ff
);
    // The frame is taken only on the pulse, since it stands unqualified otherwise.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rx_count_ff <= 32'h0000_0000;
            rx_frame_ff <= '0;
        end
        else if (frame_valid_ff)
        begin
            rx_count_ff <= rx_count_ff + 32'h0000_0001;
            rx_frame_ff <= frame_ff;
        end
    end
endmodule : aifst_ctrl_model

// ### verif/tb.sv
// Self-checking bench for the fault and status tree.
// Assumes the design answers one cycle after each strobe edge.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
// ==========================================================
// Bench top
module tb;
    logic mclk = 1'b0, srst = 1'b1, comm_fault = 1'b0, data_strobe = 1'b0, prev_stb = 1'b0;
    logic [1:0] wiring_fmt = 2'h0;
    logic [15:0] chan_calibrating = 16'h0000, at_or_below_min = 16'h0000, at_or_above_max = 16'h0000;
    aifst_pkg::aifst_chan_flags_t [15:0] alarm_flags = '0;
    aifst_pkg::aifst_frame_t frame_ff, rx_frame_ff, exp_fr;
    logic frame_valid_ff;
    logic [31:0] rx_count_ff, sent;
    int seed = 32'h0a32, miscompares = 0, check_count = 0;
    // Clock at 25 MHz.
    always #20 mclk = ~mclk;
    aifst_tree uut (.mclk(mclk), .srst(srst), .wiring_fmt(wiring_fmt), .chan_calibrating(chan_calibrating),
        .comm_fault(comm_fault), .at_or_below_min(at_or_below_min), .at_or_above_max(at_or_above_max),
        .alarm_flags(alarm_flags), .data_strobe(data_strobe), .frame_ff(frame_ff), .frame_valid_ff(frame_valid_ff));
    aifst_ctrl_model ctrl (.mclk(mclk), .srst(srst), .frame_valid_ff(frame_valid_ff), .frame_ff(frame_ff),
        .rx_count_ff(rx_count_ff), .rx_frame_ff(rx_frame_ff));
    // Expected frame worked out from the documented roll-up.
    function automatic aifst_pkg::aifst_frame_t exp_frame();
        aifst_pkg::aifst_frame_t f;
        logic [15:0] m;
        m = (wiring_fmt == aifst_pkg::FMT_SINGLE) ? aifst_pkg::MASK_SINGLE :
            (wiring_fmt == aifst_pkg::FMT_DIFF) ? aifst_pkg::MASK_DIFF :
            (wiring_fmt == aifst_pkg::FMT_HSDIFF) ? aifst_pkg::MASK_HSDIFF : aifst_pkg::WORD_ZERO;
        f = '0;
        f.chan_fault = comm_fault ? aifst_pkg::WORD_ONES : (|chan_calibrating) ? m
            : (at_or_below_min | at_or_above_max) & m;
        for (int n = 0; n < 16; n++)
        begin
            if (m[n])
                f.chan_status[n*8 +: 8] = {alarm_flags[n].cal_err, at_or_below_min[n],
                    at_or_above_max[n], alarm_flags[n][4:0]};
            f.module_fault[9] = f.module_fault[9] | (m[n] & alarm_flags[n].cal_err);
        end
        f.module_fault[15] = |f.chan_fault;
        f.module_fault[10] = |chan_calibrating;
        return f;
    endfunction : exp_frame
    // Verdict and end of run.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // Watchdog sized well above the 411 cycles the tests need.
    initial
    begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end
    // Main sequence: reset, then random frames with forced corners, strobes mostly back to back.
    initial
    begin
        exp_fr = '0;
        sent = 32'h0000_0000;
        repeat (10) @(negedge mclk);
        `CHK("reset frame", 160'h0, frame_ff)
        `CHK("reset valid", 1'b0, frame_valid_ff)
        srst = 1'b0;
        $display("test reset done");
        for (int i = 0; i < 400; i++)
        begin
            @(negedge mclk);
            `CHK("valid", prev_stb, frame_valid_ff)
            `CHK("module word", exp_fr.module_fault, frame_ff.module_fault)
            `CHK("chan fault", exp_fr.chan_fault, frame_ff.chan_fault)
            `CHK("status", exp_fr.chan_status, frame_ff.chan_status)
            wiring_fmt = i[1:0];
            // Corner spacings are odd against the format cycle so every format meets each override.
            comm_fault = (i % 13 == 5);
            chan_calibrating = (i % 5 == 3) ? 16'h0001 << ($random(seed) & 15) : 16'h0000;
            at_or_below_min = (i % 11 == 7) ? 16'h0000 : 16'($random(seed) & $random(seed));
            at_or_above_max = (i % 11 == 7) ? 16'h0000 : 16'($random(seed) & $random(seed) & $random(seed));
            alarm_flags = {$random(seed), $random(seed), $random(seed), $random(seed)};
            data_strobe = (i % 7 != 6) && (i < 399);
            if (data_strobe)
            begin
                exp_fr = exp_frame();
                sent++;
            end
            prev_stb = data_strobe;
        end
        @(negedge mclk);
        `CHK("valid", prev_stb, frame_valid_ff)
        `CHK("frames seen", sent, rx_count_ff)
        `CHK("last frame", exp_fr, rx_frame_ff)
        $display("test random frames done");
        end_of_test();
    end
endmodule : tb
